// File: card_timeout_consts.vh
// constants of the card timeout counter and synchronous card i/o block
// assumes plain verilog-2005 users that include it by bare name
//
// Contract
// R1: 71h: counter 1 off, 16-bit start-bit counter
// R2: 16-bit reload writes apply at next start
// R3: 75h: 8-bit autoreload plus 16-bit start-bit
// R4: host keeps low reload steady while counting
// R5: 7Ch: 24-bit start-bit counter, reload next start
// R6: writing 00h stops every counter stage
// R7: 85h: counter 1 autostop rx, autoreload tx
// R8: E5h: 16-bit software, counter 1 autostop/reload
// R9: host writes 05h before reloading software counter
// R10: F1h: 16-bit autostop rx, start-bit tx
// R11: F5h: both counters autostop on receive
// R12: uart idle while reset control bit low
// R13: host clears reset bit before card activation
// R14: sync mode moves i/o through bit 0
// R15: sync clock bit drives selected card clock
// R16: host finishes transfer before switching modes
// R17: deselected sync card floats with weak pull-up
// R18: aux sync clock bit drives no pin
// R19: status bit mirrors aux interrupt input level
// R20: aux change raises interrupt when enabled
// R21: aux disable blocks interrupt, status still readable
// R22: counters decrement once per etu tick
// R23: start bit starts, restarts wide counters
// R24: 8-bit reloads at terminal, wide counters stop
// R25: terminal count sets flag and interrupt
// R26: autostop window counts twelve etu ticks
// R27: unknown configuration leaves all stages stopped
`ifndef CARD_TIMEOUT_CONSTS_VH
`define CARD_TIMEOUT_CONSTS_VH

`define TOC_STOP 8'h00
`define TOC_C1_RELOAD 8'h05
`define TOC_SW16 8'h61
`define TOC_SW16_C1 8'h65
`define TOC_SW24 8'h68
`define TOC_SB16 8'h71
`define TOC_SB16_C1 8'h75
`define TOC_SB24 8'h7c
`define TOC_C1_ASTOP 8'h85
`define TOC_SW16_C1_ASTOP 8'he5
`define TOC_SB16_ASTOP 8'hf1
`define TOC_ALL_ASTOP 8'hf5

// low stage modes
`define C1_OFF 2'd0
`define C1_RELOAD 2'd1
`define C1_ASTOP 2'd2
// upper stage modes
`define HI_OFF 3'd0
`define HI_SW16 3'd1
`define HI_SB16 3'd2
`define HI_SB16_ASTOP 3'd3
`define HI_SW24 3'd4
`define HI_SB24 3'd5

`define AUTOSTOP_ETU 4'd12
`define CNT_RESET 8'h00

`endif

// File: card_timeout.v
// one timeout counter for the selected card, uart reset gate and synchronous card i/o
// assumes one ref_clk domain; card pins and aux input are asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "card_timeout_consts.vh"

module card_timeout #(
    parameter NCARD = 3
) (
    input wire ref_clk,
    input wire nrst,
    input wire [7:0] timeout_config,
    input wire config_write,
    input wire [7:0] timeout_reload_low,
    input wire [7:0] timeout_reload_mid,
    input wire [7:0] timeout_reload_high,
    input wire [7:0] etu_divider_reload,
    input wire receive_mode,
    input wire [2:0] timeout_flag_clear,
    output reg [2:0] timeout_flag,
    output reg [23:0] timeout_count,
    input wire uart_reset_ctrl_n,
    input wire [1:0] card_select,
    input wire [2:0] sync_select,
    input wire [1:0] sync_clock_ctrl,
    input wire aux_sync_clock_ctrl,
    input wire [1:0] async_card_clock,
    output reg [1:0] card_clock_pin,
    input wire uart_tx_reg,
    output reg uart_rx_reg,
    input wire [2:0] card_io_line_in,
    output reg [2:0] card_io_line_out,
    output reg [2:0] card_io_line_oe,
    output reg [2:0] card_io_pullup,
    input wire aux_irq_input,
    input wire aux_irq_disable,
    input wire aux_irq_ack,
    output reg aux_irq_level_status,
    output reg host_irq
);

// ----------------------------------------
// mode decode
// ----------------------------------------
function [1:0] c1_mode;
    input [7:0] cfg;
    begin
        case (cfg)
            `TOC_C1_RELOAD, `TOC_SW16_C1, `TOC_SB16_C1:
                c1_mode = `C1_RELOAD; // [R3]
            `TOC_C1_ASTOP, `TOC_SW16_C1_ASTOP, `TOC_ALL_ASTOP:
                c1_mode = `C1_ASTOP; // [R7] [R8] [R11]
            default:
                c1_mode = `C1_OFF; // [R1] [R6] [R10] [R27]
        endcase
    end
endfunction

function [2:0] hi_mode;
    input [7:0] cfg;
    begin
        case (cfg)
            `TOC_SW16, `TOC_SW16_C1, `TOC_SW16_C1_ASTOP:
                hi_mode = `HI_SW16; // [R8]
            `TOC_SW24:
                hi_mode = `HI_SW24;
            `TOC_SB16, `TOC_SB16_C1:
                hi_mode = `HI_SB16; // [R1] [R3]
            `TOC_SB24:
                hi_mode = `HI_SB24; // [R5]
            `TOC_SB16_ASTOP, `TOC_ALL_ASTOP:
                hi_mode = `HI_SB16_ASTOP; // [R10] [R11]
            default:
                hi_mode = `HI_OFF; // [R6] [R7] [R27]
        endcase
    end
endfunction

function is_sw;
    input [2:0] m;
    begin
        is_sw = (m == `HI_SW16) || (m == `HI_SW24);
    end
endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [2:0] io_meta_q;
reg [2:0] io_sync_q;
reg aux_meta_q;
reg aux_sync_q;
reg aux_prev_q;
reg io_prev_q;
wire [1:0] sel = (card_select > 2'd2) ? 2'd2 : card_select;
wire io_sel = io_sync_q[sel];
wire sel_sync = sync_select[sel];

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        io_meta_q <= 3'h7;
        io_sync_q <= 3'h7;
        aux_meta_q <= 1'b0;
        aux_sync_q <= 1'b0;
        aux_prev_q <= 1'b0;
        io_prev_q <= 1'b1;
    end
    else
    begin
        io_meta_q <= card_io_line_in;
        io_sync_q <= io_meta_q;
        aux_meta_q <= aux_irq_input;
        aux_sync_q <= aux_meta_q;
        aux_prev_q <= aux_sync_q;
        io_prev_q <= io_sel;
    end
end

// start bit: falling edge on the active card line, async mode only
wire start_bit = uart_reset_ctrl_n && !sel_sync
    && io_prev_q && !io_sel; // [R12] [R14]

// ----------------------------------------
// etu tick divider
// ----------------------------------------
reg [7:0] etu_div_q;
wire etu_tick = (etu_div_q == 8'h00);

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
        etu_div_q <= `CNT_RESET;
    else if (etu_tick)
        etu_div_q <= etu_divider_reload;
    else
        etu_div_q <= etu_div_q - 8'h01;
end

// ----------------------------------------
// timeout counters
// ----------------------------------------
wire [1:0] c1m = c1_mode(timeout_config);
wire [2:0] him = hi_mode(timeout_config);
wire chain24 = (him == `HI_SW24) || (him == `HI_SB24);
wire hi_sb = (him == `HI_SB16) || (him == `HI_SB16_ASTOP)
    || (him == `HI_SB24);
wire c1_sb = (c1m != `C1_OFF) && !chain24;
wire c1_astop_rx = (c1m == `C1_ASTOP) && receive_mode;
wire hi_astop_rx = (him == `HI_SB16_ASTOP) && receive_mode;

reg [7:0] c1_q;
reg [15:0] hi_q;
reg c1_run_q;
reg hi_run_q;
reg [7:0] cfg_prev_q;
reg [3:0] win_q;
reg win_run_q;
reg [2:0] tc_set;
reg [7:0] c1_d;
reg [15:0] hi_d;
reg c1_run_d;
reg hi_run_d;
reg [3:0] win_d;
reg win_run_d;
reg [23:0] w24;

always @*
begin
    c1_d = c1_q;
    hi_d = hi_q;
    c1_run_d = c1_run_q;
    hi_run_d = hi_run_q;
    win_d = win_q;
    win_run_d = win_run_q;
    tc_set = 3'b000;
    w24 = {hi_q, c1_q};
    // ---- counting, one step per etu ----
    if (etu_tick) // [R22]
    begin
        if (chain24 && hi_run_q)
        begin
            if (w24 == 24'h000000)
            begin
                hi_run_d = 1'b0; // [R24]
                tc_set = 3'b100; // [R25]
            end
            else
            begin
                w24 = w24 - 24'h000001;
                hi_d = w24[23:8];
                c1_d = w24[7:0];
            end
        end
        if (!chain24 && c1_run_q)
        begin
            if (c1_q == 8'h00)
            begin
                tc_set[0] = 1'b1; // [R25]
                if (c1_astop_rx)
                    c1_run_d = 1'b0;
                else
                    c1_d = timeout_reload_low; // [R24] [R4]
            end
            else
                c1_d = c1_q - 8'h01;
        end
        if (!chain24 && hi_run_q)
        begin
            if (hi_q == 16'h0000)
            begin
                hi_run_d = 1'b0; // [R24]
                tc_set[1] = 1'b1; // [R25]
            end
            else
                hi_d = hi_q - 16'h0001;
        end
        // ---- autostop window ----
        if (win_run_q)
        begin
            if (win_q == `AUTOSTOP_ETU - 4'd1)
            begin
                win_run_d = 1'b0;
                if (c1_astop_rx)
                    c1_run_d = 1'b0; // [R7] [R11]
                if (hi_astop_rx)
                    hi_run_d = 1'b0; // [R10] [R11]
            end
            win_d = win_q + 4'd1; // [R26]
        end
    end
    // ---- start bit: load reload values ----
    if (start_bit)
    begin
        if (c1_sb && !c1_run_q)
        begin
            c1_d = timeout_reload_low; // [R23]
            c1_run_d = 1'b1;
        end
        if (hi_sb)
        begin
            hi_d = {timeout_reload_high, timeout_reload_mid}; // [R2] [R23]
            hi_run_d = 1'b1;
            if (him == `HI_SB24)
                c1_d = timeout_reload_low; // [R5]
        end
        if ((c1_astop_rx || hi_astop_rx) && !win_run_q)
        begin
            win_d = 4'd0; // [R26]
            win_run_d = 1'b1;
        end
    end
    // ---- configuration write ----
    if (config_write)
    begin
        if (is_sw(hi_mode(timeout_config)))
        begin
            if (!(hi_run_q && is_sw(hi_mode(cfg_prev_q))))
            begin
                hi_d = {timeout_reload_high, timeout_reload_mid}; // [R9]
                hi_run_d = 1'b1;
                if (chain24)
                    c1_d = timeout_reload_low;
            end
        end
        else if (!hi_sb)
            hi_run_d = 1'b0; // [R6]
        if (c1_mode(timeout_config) == `C1_OFF)
            c1_run_d = 1'b0; // [R6] [R27]
        win_run_d = 1'b0; // [R26]
        win_d = 4'd0;
    end
end

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        c1_q <= `CNT_RESET;
        hi_q <= 16'h0000;
        c1_run_q <= 1'b0;
        hi_run_q <= 1'b0;
        win_q <= 4'd0;
        win_run_q <= 1'b0;
        cfg_prev_q <= `TOC_STOP;
        timeout_flag <= 3'b000;
        timeout_count <= 24'h000000;
    end
    else
    begin
        c1_q <= c1_d;
        hi_q <= hi_d;
        c1_run_q <= c1_run_d;
        hi_run_q <= hi_run_d;
        win_q <= win_d;
        win_run_q <= win_run_d;
        if (config_write)
            cfg_prev_q <= timeout_config;
        // set wins over clear
        timeout_flag <= (timeout_flag & ~timeout_flag_clear)
            | tc_set; // [R25]
        timeout_count <= {hi_d, c1_d};
    end
end

// ----------------------------------------
// synchronous card i/o and clocks
// ----------------------------------------
integer i;
reg aux_chg_q;

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        card_io_line_out <= 3'b000;
        card_io_line_oe <= 3'b000;
        card_io_pullup <= 3'b111;
        card_clock_pin <= 2'b00;
        uart_rx_reg <= 1'b1;
        aux_irq_level_status <= 1'b0;
        aux_chg_q <= 1'b0;
        host_irq <= 1'b0;
    end
    else
    begin
        for (i = 0; i < NCARD; i = i + 1)
        begin
            card_io_line_out[i] <= 1'b0;
            // open-drain drive low for a zero on the active sync card
            card_io_line_oe[i] <= uart_reset_ctrl_n && (sel == i)
                && sync_select[i] && !uart_tx_reg; // [R14] [R17] [R12]
            card_io_pullup[i] <= 1'b1; // [R17]
        end
        for (i = 0; i < 2; i = i + 1)
            card_clock_pin[i] <= (sync_select[i] && (sel == i))
                ? sync_clock_ctrl[i] : async_card_clock[i]; // [R15]
        // aux_sync_clock_ctrl has no pin to drive [R18]
        if (!uart_reset_ctrl_n)
            uart_rx_reg <= 1'b1; // [R12]
        else if (sel_sync)
            uart_rx_reg <= io_sel; // [R14]
        aux_irq_level_status <= aux_sync_q; // [R19]
        aux_chg_q <= (aux_chg_q && !aux_irq_ack)
            || (aux_sync_q != aux_prev_q); // [R20]
        host_irq <= (|timeout_flag)
            || (aux_chg_q && !aux_irq_disable); // [R20] [R21] [R25]
    end
end

endmodule // card_timeout

`default_nettype wire

// File: card_timeout_assertions.sv
// port checker for the card timeout block
// assumes a bind onto card_timeout and one ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module card_timeout_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] timeout_config,
    input wire logic [23:0] timeout_count,
    input wire logic [2:0] timeout_flag,
    input wire logic host_irq,
    input wire logic uart_reset_ctrl_n,
    input wire logic uart_rx_reg,
    input wire logic [1:0] card_select,
    input wire logic [2:0] sync_select,
    input wire logic [1:0] sync_clock_ctrl,
    input wire logic [1:0] card_clock_pin,
    input wire logic uart_tx_reg,
    input wire logic [2:0] card_io_line_oe,
    input wire logic aux_irq_input,
    input wire logic aux_irq_disable,
    input wire logic aux_irq_ack,
    input wire logic aux_irq_level_status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire sel_a = sync_select[0] && card_select == 2'd0;
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence stop_held;
        (timeout_config == 8'h00) [*3];
    endsequence
    sequence narrow_held;
        (timeout_config == 8'h71 || timeout_config == 8'hf1) [*3];
    endsequence
    sequence sync_tx_held;
        (sel_a && uart_reset_ctrl_n && $stable(uart_tx_reg)) [*3];
    endsequence
    sequence aux_open;
        $changed(aux_irq_input) ##0 (!aux_irq_disable && !aux_irq_ack) [*8];
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_stop_freezes: assert property (stop_held |-> $stable(timeout_count))
        else $error("count moved while stopped");
    chk_low_idle: assert property (narrow_held |-> $stable(timeout_count[7:0]))
        else $error("counter 1 moved");
    chk_uart_held: assert property (!uart_reset_ctrl_n |=> uart_rx_reg)
        else $error("rx bit not idle in uart reset");
    chk_sync_tx: assert property (sync_tx_held |-> card_io_line_oe[0] == !uart_tx_reg)
        else $error("sync tx bit not on line");
    chk_sync_clk: assert property ((sel_a && $stable(sync_clock_ctrl[0])) [*3]
        |-> card_clock_pin[0] == sync_clock_ctrl[0]) else $error("clock pin");
    chk_aux_mirror: assert property ($stable(aux_irq_input) [*6]
        |-> aux_irq_level_status == aux_irq_input) else $error("aux mirror");
    chk_aux_irq: assert property (aux_open |-> host_irq)
        else $error("aux change gave no interrupt");
    chk_aux_masked: assert property ((aux_irq_disable && timeout_flag == 3'b000) [*2]
        |-> !host_irq) else $error("masked interrupt");
    chk_flag_irq: assert property (timeout_flag != 3'b000 |=> host_irq)
        else $error("flag gave no interrupt");
endmodule // card_timeout_checker
bind card_timeout card_timeout_checker chk_u (.*);
`default_nettype wire

// File: card_model.sv
// behavioural smart card on card a's i/o line
// assumes the bench resolves the line with a weak pull-up
`timescale 1ns/1ns
`default_nettype none
module card_model (
    input wire logic ref_clk,
    input wire logic card_clock,
    input wire logic answer_en,
    output logic pull_low
);
    logic [7:0] pattern_q = 8'h35;
    initial pull_low = 1'b0;
    // ----------------------------------------
    // start bit held low for hold cycles
    // ----------------------------------------
    task automatic start_bit(input int hold);
        @(posedge ref_clk);
        pull_low <= 1'b1;
        repeat (hold) @(posedge ref_clk);
        pull_low <= 1'b0;
    endtask
    // next sync bit on each rising card clock
    always @(posedge card_clock)
        if (answer_en)
        begin
            pull_low <= ~pattern_q[0];
            pattern_q <= {pattern_q[0], pattern_q[7:1]};
        end
    always @(negedge answer_en)
        pull_low <= 1'b0;
endmodule // card_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for card_timeout, card model on card a
// assumes design, checker and card model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, nrst = 1'b0, config_write = 1'b0;
    logic [7:0] timeout_config = 8'h00, timeout_reload_high = 8'h00;
    logic [7:0] timeout_reload_low = 8'h20, timeout_reload_mid = 8'h20;
    logic receive_mode = 1'b0, uart_reset_ctrl_n = 1'b1, uart_tx_reg = 1'b1;
    logic aux_irq_input = 1'b0, aux_irq_disable = 1'b0, aux_irq_ack = 1'b0;
    logic aux_sync_clock_ctrl = 1'b0, answer_en = 1'b0;
    logic [2:0] timeout_flag_clear = 3'b000, sync_select = 3'b000;
    logic [1:0] card_select = 2'd0, sync_clock_ctrl = 2'b00;
    wire logic [2:0] timeout_flag, card_io_line_oe, card_io_pullup;
    wire logic [2:0] card_io_line_in;
    wire logic [23:0] timeout_count;
    wire logic [1:0] card_clock_pin;
    wire logic uart_rx_reg, aux_irq_level_status, host_irq, card_low;
    int n_errors = 0, cmp_count = 0;
    logic [7:0] pat = 8'h35;
    logic [15:0] hold_cnt = 16'h0000;
    // rows: config, receive, expected flags
    logic [11:0] rows [15] = '{12'h008, 12'h051, 12'h612, 12'h712,
        12'h753, 12'h7c0, 12'h858, 12'h851, 12'he5a, 12'he53,
        12'hf18, 12'hf12, 12'hf58, 12'hf53, 12'h420};
    always #10 ref_clk = ~ref_clk;
    card_timeout dut_u (
        .*,
        .etu_divider_reload(8'h01),
        .async_card_clock(2'b00),
        .card_io_line_out()
    );
    card_model card_u (.ref_clk(ref_clk), .card_clock(card_clock_pin[0]),
        .answer_en(answer_en), .pull_low(card_low));
    assign card_io_line_in = {~card_io_line_oe[2:1], ~(card_io_line_oe[0] | card_low)};
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_cfg(input logic [7:0] v);
        @(posedge ref_clk);
        timeout_config <= v;
        config_write <= 1'b1;
        @(posedge ref_clk);
        config_write <= 1'b0;
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 40 && host_irq !== lvl; i++)
            tick(1);
        if (host_irq !== lvl)
        begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic arm(input logic [7:0] v);
        write_cfg(8'h00);
        @(posedge ref_clk);
        timeout_flag_clear <= 3'b111;
        write_cfg(v);
        timeout_flag_clear <= 3'b000;
        card_u.start_bit(3);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        tick(1);
        chk(12'({timeout_flag, card_io_pullup, uart_rx_reg, host_irq}), 12'h01e);
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            receive_mode <= rows[i][3];
            arm(rows[i][11:4]);
            tick(120); // low reload kept steady while counting
            chk(12'(timeout_flag), 12'(rows[i][2:0]));
        end
        arm(8'h71);
        tick(10);
        timeout_reload_mid <= 8'hf0;
        tick(6);
        chk(12'(timeout_count[23:8] <= 16'h0020), 12'h001);
        card_u.start_bit(3);
        tick(8);
        chk(12'(timeout_count[23:8] >= 16'h00e0), 12'h001);
        arm(8'he5);
        tick(10);
        write_cfg(8'h05);
        tick(2);
        hold_cnt = timeout_count[23:8];
        tick(10);
        chk(12'(timeout_count[23:8] == hold_cnt), 12'h001);
        timeout_reload_mid <= 8'h00;
        timeout_reload_low <= 8'h08;
        arm(8'h7c);
        timeout_reload_low <= 8'h80;
        tick(40);
        chk(12'({timeout_flag, timeout_count[7:0]}), 12'h400);
        timeout_reload_mid <= 8'h20;
        uart_reset_ctrl_n <= 1'b0;
        arm(8'h71);
        tick(120);
        chk(12'({timeout_flag, uart_rx_reg}), 12'h001);
        uart_reset_ctrl_n <= 1'b1;
        sync_select <= 3'b011;
        uart_tx_reg <= 1'b0;
        tick(4);
        chk(12'(card_io_line_oe), 12'h001);
        @(posedge ref_clk);
        uart_tx_reg <= 1'b1;
        answer_en <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk);
            sync_clock_ctrl <= 2'b01;
            tick(6);
            chk(12'({card_clock_pin[0], uart_rx_reg}), 12'({1'b1, pat[k]}));
            @(posedge ref_clk);
            sync_clock_ctrl <= 2'b00;
            tick(3);
        end
        @(posedge ref_clk);
        answer_en <= 1'b0; // transfer over before switching
        card_select <= 2'd1;
        uart_tx_reg <= 1'b0;
        tick(4);
        chk(12'({card_io_pullup, card_io_line_oe}), 12'h03a);
        @(posedge ref_clk);
        card_select <= 2'd2;
        sync_select <= 3'b111;
        uart_tx_reg <= 1'b1;
        aux_sync_clock_ctrl <= 1'b1;
        tick(4);
        chk(12'(card_clock_pin), 12'h000);
        @(posedge ref_clk);
        aux_irq_input <= 1'b1;
        wait_irq(1'b1);
        tick(4);
        chk(12'(aux_irq_level_status), 12'h001);
        @(posedge ref_clk);
        aux_irq_ack <= 1'b1;
        @(posedge ref_clk);
        aux_irq_ack <= 1'b0;
        wait_irq(1'b0);
        @(posedge ref_clk);
        aux_irq_disable <= 1'b1;
        aux_irq_input <= 1'b0;
        tick(10);
        chk(12'({aux_irq_level_status, host_irq}), 12'h000);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
